// file: logic/pocp_pkg.sv
// Package for the port over-current and high-voltage input block
// Assumes an 8-bit register port and one 10 MHz clock
package pocp_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [9:0] POCP_OFS_DET_EN = 10'h2F9;
  localparam logic [9:0] POCP_OFS_IRQ_EN = 10'h2FA;
  localparam logic [9:0] POCP_OFS_FLAGS = 10'h2FB;
  localparam logic [9:0] POCP_OFS_HV_LEVEL = 10'h33A;
  localparam logic [9:0] POCP_OFS_HV_DIEN = 10'h33B;
  localparam logic [9:0] POCP_OFS_ANALOG = 10'h33D;

  // ==========================================================
  // Field positions
  localparam int POCP_BIT_SUPPLY = 7;
  localparam int POCP_BIT_PIN5 = 5;
  localparam int POCP_BIT_PIN3 = 3;
  localparam int POCP_BIT_PIN1 = 1;
  localparam int POCP_BIT_HV = 0;
  localparam int POCP_BIT_TEST_OVR = 7;
  localparam int POCP_BIT_DIRECT = 4;
  localparam int POCP_BIT_ACONN = 3;
  localparam logic [7:0] POCP_CH_MASK = 8'hAA;
  localparam logic [7:0] POCP_ANALOG_MASK = 8'h98;

  // ==========================================================
  // Reset values
  localparam logic [7:0] POCP_RST_DET_EN = 8'h00;
  localparam logic [7:0] POCP_RST_IRQ_EN = 8'h00;
  localparam logic [7:0] POCP_RST_FLAGS = 8'h00;
  localparam logic [7:0] POCP_RST_HV_DIEN = 8'h00;
  localparam logic [7:0] POCP_RST_ANALOG = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pocp_bus_req_t;

  typedef struct packed {
    logic [3:0] det_en;
    logic [3:0] oc_evt;
  } pocp_chan_t;

endpackage

// file: logic/pocp_sync2.sv
// Two-flop synchroniser for asynchronous pin levels
// Assumes the destination clock is clk with enable ce
`timescale 1ns/10ps
module pocp_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// file: logic/pocp_top.sv
// Over-current protection group and high-voltage input digital path
// Assumes detector outputs and the pin level are asynchronous to clk
//
// How it works
// - Bit 7 of the detector enable register turns the supply output detector on or off.
// - Bits 5, 3 and 1 of that register turn the matching pin detectors on or off.
// - Bits 7, 5, 3 and 1 of the interrupt enable register enable each channel's request.
// - With its enable clear a channel still records its flag but raises no request.
// - A channel's flag sets when its detector reports over-current and holds until cleared.
// - The three pin channels set their flags independently of each other.
// - The input bit reads the synchronised pin when digital input is on and analog is off.
// - In any other combination the input bit reads one.
// - The input level register is read-only and ignores writes.
// - Bit 0 of the digital input enable register turns the pin's input buffer on or off.
// - With analog on the buffer is off in run mode without the test override and follows the enable in stop mode.
// - Writing one to a flag bit clears it and writing zero leaves it alone.
// - With analog on, the test override forces the buffer on in run mode unless direct connection is chosen.
`timescale 1ns/10ps
module pocp_top
  import pocp_pkg::*;
#(
  parameter int NCH = 4
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Detectors: index 3 supply, 2 pin 5, 1 pin 3, 0 pin 1
  input wire logic [NCH-1:0] oc_detect,
  output logic [NCH-1:0] oc_detector_on,
  // High-voltage pin and mode
  input wire logic hv_pin,
  input wire logic stop_mode,
  output logic hv_input_buffer_on,
  output logic analog_connected,
  // Interrupt
  output logic oc_irq
);

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [NCH-1:0] chans(input logic [7:0] r);
    chans = {r[POCP_BIT_SUPPLY], r[POCP_BIT_PIN5], r[POCP_BIT_PIN3], r[POCP_BIT_PIN1]};
  endfunction

  function automatic logic [7:0] spread(input logic [NCH-1:0] c);
    logic [7:0] r;
    r = 8'h00;
    r[POCP_BIT_SUPPLY] = c[3];
    r[POCP_BIT_PIN5] = c[2];
    r[POCP_BIT_PIN3] = c[1];
    r[POCP_BIT_PIN1] = c[0];
    spread = r;
  endfunction

  pocp_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================
  // Synchronisers; detector levels and pin come from outside
  logic [NCH-1:0] det_s;
  logic pin_s;

  pocp_sync2 #(.WIDTH(NCH+1)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in({oc_detect, hv_pin}),
    .sync_out({det_s, pin_s})
  );

  // ==========================================================
  // Registers
  logic [7:0] det_en_q, det_en_d;
  logic [7:0] irq_en_q, irq_en_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] dien_q, dien_d;
  logic [7:0] analog_q, analog_d;
  logic [NCH-1:0] det_prev_q, det_prev_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic buf_q, buf_d;
  logic aconn_q, aconn_d;
  logic [NCH-1:0] det_on_q, det_on_d;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] evt;
  logic [NCH-1:0] clr;
  logic level_bit;
  logic wr_flags;
  pocp_chan_t ch;

  // Event on rising detector level while that detector is on
  assign rise = det_s & ~det_prev_q;
  assign ch = '{det_en: chans(det_en_q), oc_evt: rise};
  assign wr_flags = req.wr && hit(req.addr, POCP_OFS_FLAGS);
  assign clr = wr_flags ? chans(req.wdata) : '0;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign evt[g] = ch.det_en[g] & ch.oc_evt[g];
    end
  endgenerate

  // Pin level reads one unless digital path selected
  assign level_bit = (dien_q[POCP_BIT_HV] && !analog_q[POCP_BIT_ACONN]) ? pin_s : 1'b1;

  always_comb begin
    det_en_d = det_en_q;
    irq_en_d = irq_en_q;
    dien_d = dien_q;
    analog_d = analog_q;
    flags_d = flags_q;
    det_prev_d = det_prev_q;
    rdata_d = rdata_q;
    irq_d = irq_q;
    buf_d = buf_q;
    aconn_d = aconn_q;
    det_on_d = det_on_q;
    if (ce) begin
      det_prev_d = det_s;
      rdata_d = 8'h00;
      // Writes accepted whenever ce is high, no mode gating
      if (req.wr) begin
        if (hit(req.addr, POCP_OFS_DET_EN)) begin
          det_en_d = req.wdata & POCP_CH_MASK;
        end
        if (hit(req.addr, POCP_OFS_IRQ_EN)) begin
          irq_en_d = req.wdata & POCP_CH_MASK;
        end
        if (hit(req.addr, POCP_OFS_HV_DIEN)) begin
          dien_d = {7'h00, req.wdata[POCP_BIT_HV]};
        end
        if (hit(req.addr, POCP_OFS_ANALOG)) begin
          analog_d = req.wdata & POCP_ANALOG_MASK;
        end
        // Level register has no write path
      end
      // Set wins over a clear in the same cycle
      flags_d = (flags_q & ~spread(clr)) | spread(evt);
      if (req.rd) begin
        unique case (1'b1)
          hit(req.addr, POCP_OFS_DET_EN): rdata_d = det_en_q;
          hit(req.addr, POCP_OFS_IRQ_EN): rdata_d = irq_en_q;
          hit(req.addr, POCP_OFS_FLAGS): rdata_d = flags_q;
          hit(req.addr, POCP_OFS_HV_LEVEL): rdata_d = {7'h00, level_bit};
          hit(req.addr, POCP_OFS_HV_DIEN): rdata_d = dien_q;
          hit(req.addr, POCP_OFS_ANALOG): rdata_d = analog_q;
          default: rdata_d = 8'h00;
        endcase
      end
      // Flags kept even when masked; only the request is gated
      irq_d = |(chans(flags_q) & chans(irq_en_q));
      det_on_d = chans(det_en_q);
      aconn_d = analog_q[POCP_BIT_ACONN];
      if (!analog_q[POCP_BIT_ACONN]) begin
        buf_d = dien_q[POCP_BIT_HV];
      end else if (stop_mode) begin
        buf_d = dien_q[POCP_BIT_HV];
      end else begin
        // Test override keeps open-input detection usable
        buf_d = analog_q[POCP_BIT_TEST_OVR] && !analog_q[POCP_BIT_DIRECT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      det_en_q <= POCP_RST_DET_EN;
      irq_en_q <= POCP_RST_IRQ_EN;
      flags_q <= POCP_RST_FLAGS;
      dien_q <= POCP_RST_HV_DIEN;
      analog_q <= POCP_RST_ANALOG;
      det_prev_q <= '0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      buf_q <= 1'b0;
      aconn_q <= 1'b0;
      det_on_q <= '0;
    end else begin
      det_en_q <= det_en_d;
      irq_en_q <= irq_en_d;
      flags_q <= flags_d;
      dien_q <= dien_d;
      analog_q <= analog_d;
      det_prev_q <= det_prev_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      buf_q <= buf_d;
      aconn_q <= aconn_d;
      det_on_q <= det_on_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign oc_irq = irq_q;
  assign hv_input_buffer_on = buf_q;
  assign analog_connected = aconn_q;
  assign oc_detector_on = det_on_q;

  // ==========================================================
  // Checks
  property p_det_on;
    @(posedge clk) disable iff (!rst_b)
      ce |=> oc_detector_on == chans($past(det_en_q));
  endproperty
  a_det_on: assert property (p_det_on) else $error("detector enable mismatch");

  property p_pin_det;
    @(posedge clk) disable iff (!rst_b)
      (ce && req.wr && hit(req.addr, POCP_OFS_DET_EN)) |=> det_en_q[POCP_BIT_PIN5] == $past(reg_wdata[5]);
  endproperty
  a_pin_det: assert property (p_pin_det) else $error("pin detector enable not stored");

  property p_irq_en_mask;
    @(posedge clk) disable iff (!rst_b)
      (irq_en_q & ~POCP_CH_MASK) == 8'h00;
  endproperty
  a_irq_en_mask: assert property (p_irq_en_mask) else $error("irq enable bad bits");

  property p_masked;
    @(posedge clk) disable iff (!rst_b)
      (ce && irq_en_q == 8'h00) |=> !oc_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("masked flag raised irq");

  property p_flag_set;
    @(posedge clk) disable iff (!rst_b)
      (ce && evt[3]) |=> flags_q[POCP_BIT_SUPPLY];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("supply flag not set");

  property p_flag_indep;
    @(posedge clk) disable iff (!rst_b)
      (ce && !evt[1] && !clr[1] && !flags_q[POCP_BIT_PIN3]) |=> !flags_q[POCP_BIT_PIN3];
  endproperty
  a_flag_indep: assert property (p_flag_indep) else $error("pin flag set without event");

  property p_read_one;
    @(posedge clk) disable iff (!rst_b)
      (ce && req.rd && hit(req.addr, POCP_OFS_HV_LEVEL) && analog_q[POCP_BIT_ACONN])
        |=> reg_rdata == 8'h01;
  endproperty
  a_read_one: assert property (p_read_one) else $error("input bit not one");

  property p_w1c;
    @(posedge clk) disable iff (!rst_b)
      (ce && wr_flags && reg_wdata[POCP_BIT_PIN1] && !evt[0]) |=> !flags_q[POCP_BIT_PIN1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_run_analog;
    @(posedge clk) disable iff (!rst_b)
      (ce && analog_q[POCP_BIT_ACONN] && !stop_mode && !analog_q[POCP_BIT_TEST_OVR])
        |=> !hv_input_buffer_on;
  endproperty
  a_run_analog: assert property (p_run_analog) else $error("buffer on in run analog");

  property p_override;
    @(posedge clk) disable iff (!rst_b)
      (ce && analog_q == 8'h88 && !stop_mode) |=> hv_input_buffer_on;
  endproperty
  a_override: assert property (p_override) else $error("test override ignored");

  property p_irq_any;
    @(posedge clk) disable iff (!rst_b)
      (ce && |(chans(flags_q) & chans(irq_en_q))) |=> oc_irq;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("enabled flag gave no irq");

  property p_irq_en_store;
    @(posedge clk) disable iff (!rst_b)
      (ce && req.wr && hit(req.addr, POCP_OFS_IRQ_EN))
        |=> irq_en_q == ($past(reg_wdata) & POCP_CH_MASK);
  endproperty
  a_irq_en_store: assert property (p_irq_en_store) else $error("irq enable not stored");

  property p_flag_hold;
    @(posedge clk) disable iff (!rst_b)
      (ce && flags_q[POCP_BIT_SUPPLY] && !clr[3]) |=> flags_q[POCP_BIT_SUPPLY];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("supply flag lost");

  property p_held_once;
    @(posedge clk) disable iff (!rst_b)
      (ce && det_s[3] && det_prev_q[3] && !flags_q[POCP_BIT_SUPPLY]) |=> !flags_q[POCP_BIT_SUPPLY];
  endproperty
  a_held_once: assert property (p_held_once) else $error("held level set flag again");

  property p_disabled;
    @(posedge clk) disable iff (!rst_b)
      (ce && !det_en_q[POCP_BIT_PIN5] && !flags_q[POCP_BIT_PIN5]) |=> !flags_q[POCP_BIT_PIN5];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled detector set flag");

  property p_w1c_zero;
    @(posedge clk) disable iff (!rst_b)
      (ce && wr_flags && !reg_wdata[POCP_BIT_PIN5] && flags_q[POCP_BIT_PIN5])
        |=> flags_q[POCP_BIT_PIN5];
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared flag");

  property p_read_pin;
    @(posedge clk) disable iff (!rst_b)
      (ce && req.rd && hit(req.addr, POCP_OFS_HV_LEVEL) && dien_q[POCP_BIT_HV] && !analog_q[POCP_BIT_ACONN])
        |=> reg_rdata == {7'h00, $past(pin_s)};
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("input bit not pin level");

  property p_level_ro;
    @(posedge clk) disable iff (!rst_b)
      (ce && req.wr && hit(req.addr, POCP_OFS_HV_LEVEL))
        |=> $stable(det_en_q) && $stable(irq_en_q) && $stable(dien_q) && $stable(analog_q);
  endproperty
  a_level_ro: assert property (p_level_ro) else $error("level write changed state");

  property p_buf_digital;
    @(posedge clk) disable iff (!rst_b)
      (ce && !analog_q[POCP_BIT_ACONN]) |=> hv_input_buffer_on == $past(dien_q[POCP_BIT_HV]);
  endproperty
  a_buf_digital: assert property (p_buf_digital) else $error("buffer not following enable");

  property p_stop_analog;
    @(posedge clk) disable iff (!rst_b)
      (ce && analog_q[POCP_BIT_ACONN] && stop_mode) |=> hv_input_buffer_on == $past(dien_q[POCP_BIT_HV]);
  endproperty
  a_stop_analog: assert property (p_stop_analog) else $error("stop buffer not following enable");

  property p_freeze;
    @(posedge clk) disable iff (!rst_b)
      !ce |=> $stable(flags_q) && $stable(reg_rdata) && $stable(oc_irq) && $stable(det_en_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule

// file: testbench/tb_pocp_top.sv
// Self-checking bench for the port over-current and high-voltage input block
// Assumes pocp_pkg and pocp_top are compiled first; the bench drives every port
`timescale 1ns/10ps
module tb_pocp_top
  import pocp_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] oc_detect = 4'h0;
  logic [3:0] oc_detector_on;
  logic hv_pin = 1'b0;
  logic stop_mode = 1'b0;
  logic hv_input_buffer_on;
  logic analog_connected;
  logic oc_irq;
  logic [7:0] exp_q;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  pocp_top #(.NCH(4)) dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .oc_detect(oc_detect), .oc_detector_on(oc_detector_on), .hv_pin(hv_pin),
    .stop_mode(stop_mode), .hv_input_buffer_on(hv_input_buffer_on),
    .analog_connected(analog_connected), .oc_irq(oc_irq));

  // ==========================================================
  // Clock and hang guard
  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe and clears on the next cycle with ce high
  task automatic rd(input string what, input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk_byte(what, exp, reg_rdata);
  endtask

  task automatic hv_case(input logic s, input logic [7:0] an, input logic di, input logic p,
    input logic eb, input logic [7:0] el);
    @(posedge clk);
    stop_mode <= s;
    hv_pin <= p;
    wr(POCP_OFS_ANALOG, an);
    wr(POCP_OFS_HV_DIEN, {7'h00, di});
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_bit("buffer_on", eb, hv_input_buffer_on);
    chk_bit("analog_connected", an[POCP_BIT_ACONN], analog_connected);
    rd("hv_level", POCP_OFS_HV_LEVEL, el);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk_bit("irq_after_reset", 1'b0, oc_irq);
    rd("det_en_rst", POCP_OFS_DET_EN, POCP_RST_DET_EN);
    rd("flags_rst", POCP_OFS_FLAGS, POCP_RST_FLAGS);
    rd("unmapped", 10'h000, 8'h00);
    wr(POCP_OFS_DET_EN, 8'hFF);
    rd("det_en", POCP_OFS_DET_EN, POCP_CH_MASK);
    chk_byte("detector_on", 8'h0F, {4'h0, oc_detector_on});
    wr(POCP_OFS_IRQ_EN, 8'hFF);
    rd("irq_en", POCP_OFS_IRQ_EN, POCP_CH_MASK);
    wr(POCP_OFS_IRQ_EN, 8'h00);
    // Channels raised one by one; flags accumulate independently
    exp_q = 8'h00;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      oc_detect[i] <= 1'b1;
      repeat (4) @(posedge clk);
      exp_q = exp_q | (8'h02 << (2 * i));
      rd("flags_accum", POCP_OFS_FLAGS, exp_q);
      chk_bit("irq_masked", 1'b0, oc_irq);
    end
    wr(POCP_OFS_FLAGS, 8'h00);
    rd("flags_w0", POCP_OFS_FLAGS, 8'hAA);
    wr(POCP_OFS_FLAGS, 8'hAA);
    rd("flags_w1", POCP_OFS_FLAGS, 8'h00);
    @(posedge clk);
    oc_detect <= 4'h0;
    wr(POCP_OFS_DET_EN, 8'h80);
    wr(POCP_OFS_IRQ_EN, 8'h20);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_byte("detector_on_one", 8'h08, {4'h0, oc_detector_on});
    @(posedge clk);
    oc_detect <= 4'hF;
    repeat (4) @(posedge clk);
    rd("flags_gated", POCP_OFS_FLAGS, 8'h80);
    chk_bit("irq_other_en", 1'b0, oc_irq);
    wr(POCP_OFS_IRQ_EN, 8'h80);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_bit("irq_on", 1'b1, oc_irq);
    wr(POCP_OFS_FLAGS, 8'h80);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_bit("irq_cleared", 1'b0, oc_irq);
    // High-voltage input path over mode combinations
    hv_case(1'b0, 8'h00, 1'b1, 1'b0, 1'b1, 8'h00);
    hv_case(1'b0, 8'h00, 1'b1, 1'b1, 1'b1, 8'h01);
    hv_case(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 8'h01);
    hv_case(1'b0, 8'h08, 1'b1, 1'b0, 1'b0, 8'h01);
    hv_case(1'b1, 8'h08, 1'b1, 1'b0, 1'b1, 8'h01);
    hv_case(1'b1, 8'h08, 1'b0, 1'b0, 1'b0, 8'h01);
    hv_case(1'b0, 8'h88, 1'b1, 1'b0, 1'b1, 8'h01);
    hv_case(1'b0, 8'h98, 1'b1, 1'b0, 1'b0, 8'h01);
    hv_case(1'b1, 8'h88, 1'b0, 1'b0, 1'b0, 8'h01);
    hv_case(1'b0, 8'h00, 1'b1, 1'b0, 1'b1, 8'h00);
    wr(POCP_OFS_HV_LEVEL, 8'hFF);
    rd("level_ro", POCP_OFS_HV_LEVEL, 8'h00);
    wr(POCP_OFS_HV_DIEN, 8'hFF);
    rd("dien", POCP_OFS_HV_DIEN, 8'h01);
    // Enable low: no event taken, read data held
    @(posedge clk);
    oc_detect <= 4'h0;
    repeat (4) @(posedge clk);
    reg_addr <= POCP_OFS_IRQ_EN;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    ce <= 1'b0;
    oc_detect <= 4'h8;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk_byte("rdata_frozen", 8'h80, reg_rdata);
    chk_bit("irq_frozen", 1'b0, oc_irq);
    @(posedge clk);
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk_bit("irq_after_enable", 1'b1, oc_irq);
    // Second reset in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk_bit("irq_mid_reset", 1'b0, oc_irq);
    rd("flags_mid_reset", POCP_OFS_FLAGS, POCP_RST_FLAGS);
    rd("det_en_mid_reset", POCP_OFS_DET_EN, POCP_RST_DET_EN);
    end_of_test();
  end
endmodule
